/* File: design/fspa_device.sv */
// Flash self-program addressing, timing and fuse readback unit
// Behaviour
// - Address comes from sixteen-bit pointer pair
// - Low bits word index, high bits page
// - Software uses same page for erase, write
// - Load reads bytes; pointer bit zero selects
// - EEPROM write blocks commands and fuse reads
// - Software polls EEPROM flag before control write
// - Pointer one in window returns lock bits
// - Read bits clear on read or timeout
// - Closed window gives ordinary flash byte read
// - Pointer zero in window returns low fuse
// - Pointer three in window returns high fuse
// - Programmed bits read zero, unprogrammed one
// - Running write survives core reset
// - Firmware may sleep core at low supply
// - Erase or write lasts 3.7 to 4.5 ms
// - CPU stalled during erase and write
// - Store enable lasts four cycles only
`timescale 1ns/10ps
module fspa_device
#(
   parameter int PAGE_WORD_W = fspa_pkg::PAGE_WORD_W,
   parameter int OP_CYCLES = fspa_pkg::OP_CYCLES
)
(
   input wire logic ref_clk,
   input wire logic nrst,
   fspa_if.dev bus,
   input wire logic core_rst_n,
   input wire logic eeprom_busy,
   input wire logic [7:0] fuse_low_prog,
   input wire logic [7:0] fuse_high_prog,
   input wire logic [1:0] lock_prog,
   output logic [fspa_pkg::PTR_W-2:0] flash_word_addr,
   input wire logic [fspa_pkg::WORD_W-1:0] flash_rdata,
   output logic buf_wr,
   output logic buf_clr,
   output logic [PAGE_WORD_W-1:0] buf_word,
   output logic [fspa_pkg::WORD_W-1:0] buf_data,
   output logic page_erase,
   output logic page_write,
   output logic [fspa_pkg::PTR_W-PAGE_WORD_W-2:0] page_index,
   output logic op_busy,
   output logic op_done
);
   import fspa_pkg::*;

   localparam int PAGE_W = PTR_W - PAGE_WORD_W - 1;
   localparam logic [OP_CNT_W-1:0] OP_LAST = OP_CNT_W'(OP_CYCLES - 1);

   logic [4:0] cmd;
   logic [2:0] win_cnt;
   logic [OP_CNT_W-1:0] op_cnt;
   logic legal;
   logic accept_wr;
   logic store_ok;
   logic fuse_rd;
   logic long_op;
   logic op_end;
   logic [PAGE_WORD_W-1:0] word_idx;
   logic [PAGE_W-1:0] page_idx;
   logic [7:0] fuse_byte;
   logic [7:0] flash_byte;

   // Only the listed codes take effect; others are dropped
   always_comb
   begin
      case (bus.ctrl_wdata[4:0])
         CMD_LOAD, CMD_ERASE, CMD_WRITE, CMD_READ, CMD_CLRBUF:
            legal = 1'b1;
         default: legal = 1'b0;
      endcase
   end

   assign accept_wr = bus.ctrl_wr && legal && !eeprom_busy && !op_busy;

   assign store_ok = bus.store_req && (win_cnt != 3'h0)
                     && (cmd != CMD_NONE) && (cmd != CMD_READ)
                     && !eeprom_busy && !op_busy;

   // fuse read refused while eeprom busy
   assign fuse_rd = bus.load_req && (cmd == CMD_READ)
                    && (win_cnt != 3'h0) && !eeprom_busy;

   assign long_op = (cmd == CMD_ERASE) || (cmd == CMD_WRITE);
   // Last busy cycle; enable drops together with busy
   assign op_end = op_busy && (op_cnt == '0);

   assign word_idx = bus.ptr[PAGE_WORD_W:1];
   assign page_idx = bus.ptr[PTR_W-1:PAGE_WORD_W+1];
   assign flash_word_addr = bus.ptr[PTR_W-1:1];

   always_comb
   begin
      case (bus.ptr)
         ADDR_LOCK: fuse_byte = {LOCK_PAD, ~lock_prog};
         ADDR_FUSE_LOW: fuse_byte = ~fuse_low_prog;
         ADDR_FUSE_HIGH: fuse_byte = ~fuse_high_prog;
         default: fuse_byte = FUSE_NONE;
      endcase
   end

   assign flash_byte = bus.ptr[0] ? flash_rdata[15:8] : flash_rdata[7:0];

   assign bus.cpu_stall = op_busy;

   // Enable stays visible until a long operation ends
   assign bus.ctrl_rdata = {3'h0, cmd[4:1], cmd[CB_EN] | op_busy};

   // Command latch and its expiry window
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         cmd <= CMD_NONE;
         win_cnt <= 3'h0;
      end
      else if (!core_rst_n)
      begin
         // A long op keeps its own state through core reset
         cmd <= (op_busy && !op_end) ? cmd : CMD_NONE;
         win_cnt <= 3'h0;
      end
      else if (accept_wr)
      begin
         cmd <= bus.ctrl_wdata[4:0];
         win_cnt <= (bus.ctrl_wdata[4:0] == CMD_READ) ? LOAD_WIN
                                                      : STORE_WIN;
      end
      else if (store_ok)
      begin
         cmd <= long_op ? cmd : CMD_NONE;
         win_cnt <= 3'h0;
      end
      else if (fuse_rd)
      begin
         cmd <= CMD_NONE;
         win_cnt <= 3'h0;
      end
      else if (op_end)
         cmd <= CMD_NONE;
      else if ((win_cnt == 3'h1) && !op_busy)
      begin
         cmd <= CMD_NONE;
         win_cnt <= 3'h0;
      end
      else if (win_cnt != 3'h0)
         win_cnt <= win_cnt - 3'h1;
   end

   // Erase and write timer; core reset does not touch it
   // Timing is from the system clock, a fixed count of OP_CYCLES cycles
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         op_busy <= 1'b0;
         op_cnt <= '0;
         op_done <= 1'b0;
         page_erase <= 1'b0;
         page_write <= 1'b0;
         page_index <= '0;
      end
      else
      begin
         op_done <= 1'b0;
         if (store_ok && long_op)
         begin
            op_busy <= 1'b1;
            op_cnt <= OP_LAST;
            page_erase <= (cmd == CMD_ERASE);
            page_write <= (cmd == CMD_WRITE);
            page_index <= page_idx;
         end
         else if (op_busy)
         begin
            if (op_cnt == '0)
            begin
               op_busy <= 1'b0;
               op_done <= 1'b1;
               page_erase <= 1'b0;
               page_write <= 1'b0;
            end
            else
               op_cnt <= op_cnt - 1'b1;
         end
      end
   end

   // Page buffer strobes, one cycle each
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         buf_wr <= 1'b0;
         buf_clr <= 1'b0;
         buf_word <= '0;
         buf_data <= 16'h0000;
      end
      else
      begin
         buf_wr <= store_ok && (cmd == CMD_LOAD);
         buf_clr <= store_ok && (cmd == CMD_CLRBUF);
         if (store_ok && (cmd == CMD_LOAD))
         begin
            buf_word <= word_idx;
            buf_data <= bus.store_data;
         end
      end
   end

   // Load answer one cycle after the request
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         bus.load_valid <= 1'b0;
         bus.load_data <= 8'h00;
         bus.eeprom_flag <= 1'b0;
      end
      else
      begin
         bus.eeprom_flag <= eeprom_busy;
         bus.load_valid <= bus.load_req;
         if (bus.load_req)
            bus.load_data <= fuse_rd ? fuse_byte : flash_byte;
      end
   end
endmodule

/* File: design/fspa_pkg.sv */
// Shared constants for the flash self-program addressing pair
package fspa_pkg;
   // Bus widths
   localparam int PTR_W = 16;
   localparam int BYTE_W = 8;
   localparam int WORD_W = 16;
   localparam int CMD_W = 5;
   // Default page geometry: words per page as log2
   localparam int PAGE_WORD_W = 4;
   // Control register field positions
   localparam int CB_EN = 0;
   localparam int CB_ERASE = 1;
   localparam int CB_WRITE = 2;
   localparam int CB_FUSE_LOCK_READ_BIT = 3;
   localparam int CB_CLRBUF = 4;
   // Idle value and accepted command codes in the low five control bits
   localparam logic [4:0] CMD_NONE = 5'h00;
   localparam logic [4:0] CMD_LOAD = 5'h01;
   localparam logic [4:0] CMD_ERASE = 5'h03;
   localparam logic [4:0] CMD_WRITE = 5'h05;
   localparam logic [4:0] CMD_READ = 5'h09;
   localparam logic [4:0] CMD_CLRBUF = 5'h11;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   // Windows after a control write, in CPU cycles
   localparam logic [2:0] STORE_WIN = 3'h4;
   localparam logic [2:0] LOAD_WIN = 3'h3;
   // Pointer values that select fuse and lock bytes
   localparam logic [15:0] ADDR_FUSE_LOW = 16'h0000;
   localparam logic [15:0] ADDR_LOCK = 16'h0001;
   localparam logic [15:0] ADDR_FUSE_HIGH = 16'h0003;
   // Unused lock bits and unmapped fuse reads show unprogrammed
   localparam logic [5:0] LOCK_PAD = 6'h3f;
   localparam logic [7:0] FUSE_NONE = 8'hff;
   // Flash operation time window
   localparam int CLK_PERIOD_NS = 10;
   localparam int OP_MIN_US = 3700;
   localparam int OP_MAX_US = 4500;
   localparam int OP_MIN_CYC = (OP_MIN_US * 1000 + CLK_PERIOD_NS - 1)
                               / CLK_PERIOD_NS;
   localparam int OP_MAX_CYC = (OP_MAX_US * 1000) / CLK_PERIOD_NS;
   localparam int OP_CYCLES = (OP_MIN_CYC + OP_MAX_CYC) / 2;
   localparam int OP_CNT_W = 20;
   // Host request codes
   localparam logic [2:0] OP_BUF_LOAD = 3'h0;
   localparam logic [2:0] OP_ERASE = 3'h1;
   localparam logic [2:0] OP_WRITE = 3'h2;
   localparam logic [2:0] OP_PROGRAM = 3'h3;
   localparam logic [2:0] OP_FUSE = 3'h4;
   localparam logic [2:0] OP_READ = 3'h5;
   localparam logic [2:0] OP_CLRBUF = 3'h6;
endpackage

/* File: design/fspa_if.sv */
// Interface between CPU core and self-program unit
`timescale 1ns/10ps
interface fspa_if;
   logic ctrl_wr;
   logic [7:0] ctrl_wdata;
   logic [7:0] ctrl_rdata;
   logic [15:0] ptr;
   logic [15:0] store_data;
   logic store_req;
   logic load_req;
   logic load_valid;
   logic [7:0] load_data;
   logic cpu_stall;
   logic eeprom_flag;

   modport dev (
      input ctrl_wr, ctrl_wdata, ptr, store_data, store_req, load_req,
      output ctrl_rdata, load_valid, load_data, cpu_stall, eeprom_flag
   );
   modport cpu (
      output ctrl_wr, ctrl_wdata, ptr, store_data, store_req, load_req,
      input ctrl_rdata, load_valid, load_data, cpu_stall, eeprom_flag
   );
endinterface

/* File: design/fspa_cpu.sv */
// CPU-side sequencer issuing control writes, stores and loads
`timescale 1ns/10ps
module fspa_cpu
(
   input wire logic ref_clk,
   input wire logic nrst,
   fspa_if.cpu bus,
   input wire logic req_valid,
   input wire logic [2:0] req_op,
   input wire logic [fspa_pkg::PTR_W-1:0] req_addr,
   input wire logic [fspa_pkg::WORD_W-1:0] req_data,
   output logic req_ready,
   output logic rsp_valid,
   output logic [fspa_pkg::BYTE_W-1:0] rsp_data,
   input wire logic low_supply,
   output logic sleeping
);
   import fspa_pkg::*;

   typedef enum logic [2:0] {
      S_IDLE, S_POLL, S_CTRL, S_ISSUE, S_WAIT, S_SLEEP
   } fspa_cpu_state_e;

   fspa_cpu_state_e state;
   logic [2:0] op;
   logic phase;
   logic [7:0] ptr_hi;
   logic [7:0] ptr_lo;
   logic [15:0] data_q;
   logic [7:0] cmd_q;
   logic is_load;
   logic [4:0] next_cmd;

   // Command code for the request and its phase
   always_comb
   begin
      case (op)
         OP_BUF_LOAD: next_cmd = CMD_LOAD;
         OP_ERASE: next_cmd = CMD_ERASE;
         OP_WRITE: next_cmd = CMD_WRITE;
         OP_PROGRAM: next_cmd = phase ? CMD_WRITE : CMD_ERASE;
         OP_FUSE: next_cmd = CMD_READ;
         OP_CLRBUF: next_cmd = CMD_CLRBUF;
         default: next_cmd = CMD_NONE;
      endcase
   end

   assign is_load = (op == OP_FUSE) || (op == OP_READ);
   assign req_ready = (state == S_IDLE) && !low_supply;
   assign sleeping = (state == S_SLEEP);
   assign bus.ctrl_wr = (state == S_CTRL);
   assign bus.store_req = (state == S_ISSUE) && !is_load;
   assign bus.load_req = (state == S_ISSUE) && is_load;
   assign bus.ctrl_wdata = cmd_q;
   // Pointer pair drives the target address
   assign bus.ptr = {ptr_hi, ptr_lo};
   assign bus.store_data = data_q;

   // Request capture; pointer held for the whole sequence
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         op <= OP_READ;
         ptr_hi <= 8'h00;
         ptr_lo <= 8'h00;
         data_q <= 16'h0000;
      end
      else if (req_valid && req_ready)
      begin
         op <= req_op;
         ptr_hi <= req_addr[15:8];
         ptr_lo <= req_addr[7:0];
         data_q <= req_data;
      end
   end

   // Sequence of poll, control write, instruction, wait; plain reads start at the instruction
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         state <= S_IDLE;
         phase <= 1'b0;
         cmd_q <= CTRL_RESET;
         rsp_valid <= 1'b0;
         rsp_data <= 8'h00;
      end
      else
      begin
         rsp_valid <= 1'b0;
         case (state)
            S_IDLE:
            begin
               phase <= 1'b0;
               if (low_supply)
                  state <= S_SLEEP;
               else if (req_valid)
                  state <= (req_op == OP_READ) ? S_ISSUE : S_POLL;
            end
            S_POLL:
            begin
               if (!bus.eeprom_flag)
               begin
                  cmd_q <= {3'h0, next_cmd};
                  state <= S_CTRL;
               end
            end
            // Instruction follows one cycle after the control write
            S_CTRL: state <= S_ISSUE;
            S_ISSUE: state <= S_WAIT;
            S_WAIT:
            begin
               if (is_load)
               begin
                  if (bus.load_valid)
                  begin
                     rsp_data <= bus.load_data;
                     rsp_valid <= 1'b1;
                     state <= S_IDLE;
                  end
               end
               else if (!bus.cpu_stall)
               begin
                  if ((op == OP_PROGRAM) && !phase)
                  begin
                     phase <= 1'b1;
                     state <= S_POLL;
                  end
                  else
                  begin
                     rsp_valid <= 1'b1;
                     state <= S_IDLE;
                  end
               end
            end
            S_SLEEP:
            begin
               if (!low_supply)
                  state <= S_IDLE;
            end
            default: state <= S_IDLE;
         endcase
      end
   end
endmodule

/* File: tb/fspa_chk.sv */
// Interface checks between CPU side and self-program unit
`timescale 1ns/10ps
module fspa_chk
(
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic ctrl_wr,
   input wire logic [7:0] ctrl_wdata,
   input wire logic [7:0] ctrl_rdata,
   input wire logic [15:0] ptr,
   input wire logic store_req,
   input wire logic load_req,
   input wire logic load_valid,
   input wire logic [7:0] load_data,
   input wire logic cpu_stall,
   input wire logic eeprom_flag
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   // Load timing and fuse mode effects
   a_load_answer: assert property (load_req |=> load_valid)
      else $error("load not answered next cycle");
   a_lock_read: assert property (ctrl_rdata == 8'h09 && load_req
      && ptr == 16'h0001 |=> load_data[7:2] == 6'h3f)
      else $error("lock read pad bits wrong");
   a_fuse_clear: assert property (ctrl_rdata == 8'h09 && load_req
      |=> ctrl_rdata == 8'h00) else $error("fuse read left cmd set");
   // Window lapses after four idle cycles
   a_window_close: assert property (($rose(ctrl_rdata[0])
      && !cpu_stall) ##0 (!ctrl_wr && !store_req)[*4] |=> !ctrl_rdata[0])
      else $error("store window stayed open");
   // Stall only follows an accepted store, and lasts
   a_stall_cause: assert property ($rose(cpu_stall) |->
      $past(store_req)) else $error("stall without store");
   a_stall_span: assert property ($rose(cpu_stall) |->
      cpu_stall[*8]) else $error("operation ended too soon");
   a_stall_done: assert property ($fell(cpu_stall) |->
      !ctrl_rdata[0]) else $error("enable kept after operation");
   // Refusals leave no trace
   a_eeprom_block: assert property (ctrl_wr && !ctrl_rdata[0]
      ##1 eeprom_flag |-> !ctrl_rdata[0]) else $error("write during eeprom");
   a_store_refused: assert property (store_req
      && ctrl_rdata == 8'h00 |=> !cpu_stall)
      else $error("store without command ran");
endmodule

/* File: tb/flash_self_program_addressing_tb.sv */
// Self-checking bench for the CPU and self-program unit pair
`timescale 1ns/10ps
module flash_self_program_addressing_tb;
   import fspa_pkg::*;
   typedef struct {logic [2:0] op; logic [15:0] a; logic [7:0] e;} fspa_row_s;
   logic ref_clk = 1'b0;
   logic nrst = 1'b0;
   logic core_rst_n = 1'b1;
   logic eeprom_busy = 1'b0;
   logic low_supply = 1'b0;
   logic req_valid = 1'b0;
   logic [2:0] req_op = 3'h0;
   logic [15:0] req_addr = 16'h0000;
   logic [15:0] req_data = 16'h0000;
   logic req_ready, rsp_valid, sleeping, buf_wr, buf_clr;
   logic page_erase, page_write, op_busy, op_done;
   logic [7:0] rsp_data, got;
   logic [14:0] flash_word_addr;
   logic [15:0] flash_rdata, buf_data, bd_seen;
   logic [3:0] buf_word, bw_seen;
   logic [10:0] page_index, pg_seen;
   logic pe_seen, pw_seen;
   int err_total = 0;
   int num_checks = 0;
   int busy_n = 0;
   int done_n = 0;
   int clr_n = 0;
   // Flash data, lock and fuse bits (high byte also cross-checks order)
   fspa_row_s rows [7] = '{'{3'h5, 16'h0124, 8'h92},
      '{3'h5, 16'h0125, 8'h37}, '{3'h4, 16'h0001, 8'hfe},
      '{3'h4, 16'h0000, 8'hf0}, '{3'h4, 16'h0003, 8'h7e},
      '{3'h4, 16'h0002, 8'hff}, '{3'h5, 16'h0001, 8'ha5}};
   fspa_if fspa_if_inst ();
   assign flash_rdata = {flash_word_addr[7:0] ^ 8'ha5, flash_word_addr[7:0]};
   fspa_cpu fspa_cpu_inst (.ref_clk, .nrst, .bus(fspa_if_inst), .req_valid,
      .req_op, .req_addr, .req_data, .req_ready, .rsp_valid, .rsp_data,
      .low_supply, .sleeping);
   fspa_device #(.OP_CYCLES(20)) fspa_device_inst (.ref_clk, .nrst,
      .bus(fspa_if_inst), .core_rst_n, .eeprom_busy,
      .fuse_low_prog(8'h0f), .fuse_high_prog(8'h81), .lock_prog(2'b01),
      .flash_word_addr, .flash_rdata, .buf_wr, .buf_clr, .buf_word, .buf_data,
      .page_erase, .page_write, .page_index, .op_busy, .op_done);
   fspa_chk fspa_chk_inst (.ref_clk, .nrst, .ctrl_wr(fspa_if_inst.ctrl_wr),
      .ctrl_wdata(fspa_if_inst.ctrl_wdata), .ptr(fspa_if_inst.ptr),
      .ctrl_rdata(fspa_if_inst.ctrl_rdata), .load_req(fspa_if_inst.load_req),
      .store_req(fspa_if_inst.store_req), .load_data(fspa_if_inst.load_data),
      .load_valid(fspa_if_inst.load_valid), .cpu_stall(fspa_if_inst.cpu_stall),
      .eeprom_flag(fspa_if_inst.eeprom_flag));
   always #5 ref_clk = ~ref_clk;
   // Record what reaches the page buffer and array
   always @(posedge ref_clk)
   begin
      if (op_busy)
         busy_n <= busy_n + 1;
      if (op_busy)
         pg_seen <= page_index;
      pe_seen <= pe_seen | page_erase;
      pw_seen <= pw_seen | page_write;
      if (buf_wr)
         bw_seen <= buf_word;
      if (buf_wr)
         bd_seen <= buf_data;
      if (buf_clr)
         clr_n <= clr_n + 1;
      if (op_done)
         done_n <= done_n + 1;
   end
   task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         err_total++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_of_test;
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // Bounded waits: a hang counts as a mismatch
   task automatic tick_until(input int lim);
      int n;
      n = 0;
      while (fspa_if_inst.ctrl_wr !== 1'b1 && n < lim)
      begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      if (n >= lim)
      begin
         err_total++;
         end_of_test;
      end
   endtask
   task automatic do_req(input logic [2:0] op, input logic [15:0] addr);
      int n;
      n = 0;
      while (req_ready !== 1'b1 && n < 300)
      begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      if (n >= 300)
      begin
         err_total++;
         end_of_test;
      end
      req_op = op;
      req_addr = addr;
      req_data = 16'hbeef;
      req_valid = 1'b1;
      @(posedge ref_clk);
      #1;
      req_valid = 1'b0;
      n = 0;
      while (rsp_valid !== 1'b1 && n < 300)
      begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      if (n >= 300)
      begin
         err_total++;
         end_of_test;
      end
      got = rsp_data;
   endtask
   initial
   begin
      repeat (6) @(posedge ref_clk);
      #1;
      chk({op_busy, req_ready, rsp_valid}, 3'b010);
      nrst = 1'b1;
      // Flash, lock and fuse reads through the table
      foreach (rows[i])
      begin
         do_req(rows[i].op, rows[i].a);
         chk(got, rows[i].e);
      end
      do_req(OP_BUF_LOAD, 16'h0036);
      chk({bw_seen, bd_seen}, 20'hb_beef);
      do_req(OP_CLRBUF, 16'h0000);
      chk(clr_n, 1);
      // Erase, write, then both on one page; core reset mid-operation
      for (int k = 1; k < 4; k++)
      begin
         busy_n = 0;
         done_n = 0;
         pe_seen = 1'b0;
         pw_seen = 1'b0;
         fork
            do_req(3'(k), 16'h1234);
            begin
               repeat (8) @(posedge ref_clk);
               #1;
               core_rst_n = 1'b0;
               @(posedge ref_clk);
               #1;
               core_rst_n = 1'b1;
            end
         join
         chk(busy_n, (k == 3) ? 40 : 20);
         chk(done_n, (k == 3) ? 2 : 1);
         chk({pg_seen, pe_seen, pw_seen}, {11'h91, k != 2, k > 1});
      end
      // EEPROM write starting with the control write
      for (int k = 0; k < 2; k++)
      begin
         busy_n = 0;
         fork
            do_req(k ? OP_FUSE : OP_ERASE, 16'h0001);
            begin
               tick_until(60);
               eeprom_busy = 1'b1;
            end
         join
         eeprom_busy = 1'b0;
         chk(k ? got : busy_n, k ? 8'ha5 : 0);
      end
      low_supply = 1'b1;
      @(posedge ref_clk);
      #1;
      chk({sleeping, req_ready}, 2'b10);
      end_of_test;
   end
endmodule
